// *** logic/mcf_pkg.sv ***
// Constants and types for the machine check frame logic.
// Assumes a 32-bit processor datapath and a word-addressed AHB-Lite register map.
package mcf_pkg;

  // Register byte offsets
  localparam logic [7:0] MCF_OFF_CTRL   = 8'h00;
  localparam logic [7:0] MCF_OFF_SP     = 8'h04;
  localparam logic [7:0] MCF_OFF_LVLMSK = 8'h08;
  localparam logic [7:0] MCF_OFF_STATUS = 8'h0C;
  localparam logic [7:0] MCF_OFF_CODE   = 8'h10;
  localparam logic [7:0] MCF_OFF_COUNT  = 8'h14;

  // Field positions
  localparam int MCF_CTRL_EN_BIT      = 0;
  localparam int MCF_ST_BUSY_BIT      = 0;
  localparam int MCF_ST_OVERRUN_BIT   = 1;
  localparam int MCF_ST_NONRECOV_BIT  = 2;
  localparam int MCF_ST_CANTRST_BIT   = 3;
  localparam int MCF_IS2_CANTRST_BIT  = 15;
  localparam int MCF_VA_SYSTEM_BIT    = 31;
  localparam int MCF_VA_SPACE1_BIT    = 30;

  // Reset values
  localparam logic [31:0] MCF_RST_CTRL   = 32'h0000_0001;
  localparam logic [31:0] MCF_RST_SP     = 32'h0000_0000;
  localparam logic [31:0] MCF_RST_LVLMSK = 32'hFFFF_FFFF;

  // Frame layout
  localparam logic [31:0] MCF_BYTE_COUNT  = 32'h0000_0010;
  localparam int          MCF_FRAME_WORDS = 7;
  localparam logic [31:0] MCF_FRAME_BYTES = 32'h0000_001C;

  // Machine check codes
  localparam logic [31:0] MCF_CODE_MISS_S0   = 32'h0000_0005;
  localparam logic [31:0] MCF_CODE_MISS_S1   = 32'h0000_0006;
  localparam logic [31:0] MCF_CODE_MOD_S0    = 32'h0000_0007;
  localparam logic [31:0] MCF_CODE_MOD_S1    = 32'h0000_0008;
  localparam logic [31:0] MCF_CODE_IPL       = 32'h0000_0009;
  localparam logic [31:0] MCF_CODE_STRING    = 32'h0000_000A;
  localparam logic [31:0] MCF_CODE_RD_PROC   = 32'h0000_0080;
  localparam logic [31:0] MCF_CODE_RD_SYS    = 32'h0000_0081;
  localparam logic [31:0] MCF_CODE_WR_PROC   = 32'h0000_0082;
  localparam logic [31:0] MCF_CODE_WR_SYS    = 32'h0000_0083;

  // What a failing memory access was touching
  typedef enum logic [2:0] {
    MCF_TGT_OPERAND   = 3'h0,
    MCF_TGT_PROCESS_PAGE_TABLE_ENTRY      = 3'h1,
    MCF_TGT_INTERLOCK = 3'h2,
    MCF_TGT_SYSTEM_PAGE_TABLE_ENTRY      = 3'h3,
    MCF_TGT_PCB       = 3'h4,
    MCF_TGT_VECTOR    = 3'h5,
    MCF_TGT_STACKPTR  = 3'h6
  } mcf_target_t;

  // String move sequencer states; 3 is the impossible one
  localparam logic [1:0] MCF_STR_FORWARD  = 2'h0;
  localparam logic [1:0] MCF_STR_BACKWARD = 2'h1;
  localparam logic [1:0] MCF_STR_FILL     = 2'h2;

  typedef enum logic [1:0] {
    MCF_ST_IDLE = 2'h0,
    MCF_ST_PUSH = 2'h1
  } mcf_state_t;

endpackage

// *** logic/mcf_code_enc.sv ***
// Machine check code encoder: turns detected error conditions into a code.
// Assumes all condition inputs are qualified pulses on the processor clock.
`timescale 1ns/1ps
`default_nettype none
module mcf_code_enc
  import mcf_pkg::*;
(
  input  wire logic              mem_err_valid,
  input  wire logic              mem_err_write,
  input  wire mcf_pkg::mcf_target_t mem_err_target,
  input  wire logic              pte_check_valid,
  input  wire logic              pte_check_modify,
  input  wire logic [31:0]       pte_check_va,
  input  wire logic              irq_req_valid,
  input  wire logic [4:0]        irq_req_level,
  input  wire logic [31:0]       level_mask,
  input  wire logic              str_check_valid,
  input  wire logic [1:0]        str_check_state,
  output logic                   hit,
  output logic [31:0]            code,
  output logic                   nonrecov
);

  logic sys_target;

  always_comb
  begin
    sys_target = (mem_err_target == MCF_TGT_SYSTEM_PAGE_TABLE_ENTRY) || (mem_err_target == MCF_TGT_PCB) ||
                 (mem_err_target == MCF_TGT_VECTOR) || (mem_err_target == MCF_TGT_STACKPTR);
    hit      = 1'b0;
    code     = 32'h0000_0000;
    nonrecov = 1'b1;
    // Memory errors first: they carry the faulting access itself
    if (mem_err_valid)
    begin
      hit = 1'b1;
      if (mem_err_write)
        code = sys_target ? MCF_CODE_WR_SYS : MCF_CODE_WR_PROC;
      else
      begin
        code     = sys_target ? MCF_CODE_RD_SYS : MCF_CODE_RD_PROC;
        nonrecov = 1'b0;
      end
    end
    else if (pte_check_valid && !pte_check_va[MCF_VA_SYSTEM_BIT])
    begin
      hit = 1'b1;
      if (pte_check_modify)
        code = pte_check_va[MCF_VA_SPACE1_BIT] ? MCF_CODE_MOD_S1 : MCF_CODE_MOD_S0;
      else
        code = pte_check_va[MCF_VA_SPACE1_BIT] ? MCF_CODE_MISS_S1 : MCF_CODE_MISS_S0;
    end
    else if (irq_req_valid && !level_mask[irq_req_level])
    begin
      hit  = 1'b1;
      code = MCF_CODE_IPL;
    end
    else if (str_check_valid && (str_check_state != MCF_STR_FORWARD) &&
             (str_check_state != MCF_STR_BACKWARD) && (str_check_state != MCF_STR_FILL))
    begin
      hit  = 1'b1;
      code = MCF_CODE_STRING;
    end
  end

endmodule // mcf_code_enc
`default_nettype wire

// *** logic/mcf_ahb_slave.sv ***
// AHB-Lite slave front end: zero-wait, always OKAY, single word transfers.
// Assumes the owner decodes rd_addr combinationally and takes wr_en as a strobe.
`timescale 1ns/1ps
`default_nettype none
module mcf_ahb_slave
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data
);

  logic        wpend_reg;
  logic        wpend_next;
  logic [7:0]  waddr_reg;
  logic [7:0]  waddr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        active;

  always_comb
  begin
    active      = hsel && htrans[1] && hready;
    wpend_next  = active && hwrite;
    waddr_next  = active ? {haddr[7:2], 2'b00} : waddr_reg;
    // Read data is latched at the address phase edge so it stands in the data phase
    hrdata_next = (active && !hwrite) ? rd_data : hrdata_reg;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wpend_reg  <= 1'b0;
      waddr_reg  <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wpend_reg  <= wpend_next;
      waddr_reg  <= waddr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign rd_addr   = {haddr[7:2], 2'b00};
  assign wr_en     = wpend_reg;
  assign wr_addr   = waddr_reg;
  assign wr_data   = hwdata;
  assign hrdata    = hrdata_reg;
  assign hreadyout = hresetn;
  assign hresp     = 1'b0;

endmodule // mcf_ahb_slave
`default_nettype wire

// *** logic/mcf_frame_logic.sv ***
// Machine check frame logic: detects machine checks, snapshots the machine
// state and pushes the seven-longword frame through a stack write port.
// Assumes processor-side inputs are on hclk and that the stack port
// accepts a word on any edge where stk_valid and stk_ready are both high.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - push status, pc, four parameters, count
// - byte count longword is always sixteen
// - push full 32-bit machine check code
// - codes 5/6 for process-space pte miss
// - codes 7/8 for process-space modify pte
// - code 9 for unassigned interrupt level
// - code A for impossible string move state
// - code 80 for process-side read errors
// - code 81 for system-side read errors
// - code 82 for process-side write errors
// - code 83 for system-side write errors
// - read error frame describes faulting instruction
// - write errors are non-recoverable
// - internal state two bit 15 holds restart
module mcf_frame_logic
  import mcf_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire logic                 mem_err_valid,
  input  wire logic                 mem_err_write,
  input  wire mcf_pkg::mcf_target_t mem_err_target,
  input  wire logic                 pte_check_valid,
  input  wire logic                 pte_check_modify,
  input  wire logic [31:0]          pte_check_va,
  input  wire logic                 irq_req_valid,
  input  wire logic [4:0]           irq_req_level,
  input  wire logic                 str_check_valid,
  input  wire logic [1:0]           str_check_state,
  input  wire logic [31:0]          cur_pc,
  input  wire logic [31:0]          cur_psl,
  input  wire logic [31:0]          cur_va,
  input  wire logic [31:0]          cur_state1,
  input  wire logic [31:0]          cur_state2,
  input  wire logic                 cannot_restart_flag,
  output logic                      stk_valid,
  output logic [31:0]               stk_addr,
  output logic [31:0]               stk_wdata,
  input  wire logic                 stk_ready,
  output logic                      mc_busy,
  output logic                      mc_taken
);

  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        enc_hit;
  logic [31:0] enc_code;
  logic        enc_nonrecov;

  // Register group
  logic        ctrl_en_reg;
  logic        ctrl_en_next;
  logic [31:0] sp_reg;
  logic [31:0] sp_next;
  logic [31:0] lvlmask_reg;
  logic [31:0] lvlmask_next;
  logic        overrun_reg;
  logic        overrun_next;
  logic [31:0] last_code_reg;
  logic [31:0] last_code_next;
  logic        last_nonrecov_reg;
  logic        last_nonrecov_next;
  logic        last_cantrst_reg;
  logic        last_cantrst_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;

  // Push group
  mcf_state_t  state_reg;
  mcf_state_t  state_next;
  logic [2:0]  idx_reg;
  logic [2:0]  idx_next;
  logic [31:0] base_reg;
  logic [31:0] base_next;
  logic [31:0] frame_reg  [MCF_FRAME_WORDS];
  logic [31:0] frame_next [MCF_FRAME_WORDS];
  logic        stk_valid_reg;
  logic        stk_valid_next;
  logic [31:0] stk_addr_reg;
  logic [31:0] stk_addr_next;
  logic [31:0] stk_wdata_reg;
  logic [31:0] stk_wdata_next;
  logic        taken_reg;
  logic        taken_next;
  logic        busy_reg;
  logic        busy_next;

  logic        start;
  logic        accept;
  logic        last_word;

  mcf_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  mcf_code_enc u_enc (
    .mem_err_valid    (mem_err_valid),
    .mem_err_write    (mem_err_write),
    .mem_err_target   (mem_err_target),
    .pte_check_valid  (pte_check_valid),
    .pte_check_modify (pte_check_modify),
    .pte_check_va     (pte_check_va),
    .irq_req_valid    (irq_req_valid),
    .irq_req_level    (irq_req_level),
    .level_mask       (lvlmask_reg),
    .str_check_valid  (str_check_valid),
    .str_check_state  (str_check_state),
    .hit              (enc_hit),
    .code             (enc_code),
    .nonrecov         (enc_nonrecov)
  );

  // Read decode; unmapped offsets read as zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      MCF_OFF_CTRL:   rd_data[MCF_CTRL_EN_BIT] = ctrl_en_reg;
      MCF_OFF_SP:     rd_data = sp_reg;
      MCF_OFF_LVLMSK: rd_data = lvlmask_reg;
      MCF_OFF_STATUS:
      begin
        rd_data[MCF_ST_BUSY_BIT]     = busy_reg;
        rd_data[MCF_ST_OVERRUN_BIT]  = overrun_reg;
        rd_data[MCF_ST_NONRECOV_BIT] = last_nonrecov_reg;
        rd_data[MCF_ST_CANTRST_BIT]  = last_cantrst_reg;
      end
      MCF_OFF_CODE:   rd_data = last_code_reg;
      MCF_OFF_COUNT:  rd_data = count_reg;
      default:        rd_data = 32'h0000_0000;
    endcase
  end

  assign start     = enc_hit && ctrl_en_reg && (state_reg == MCF_ST_IDLE);
  assign accept    = stk_valid_reg && stk_ready;
  assign last_word = (idx_reg == 3'(MCF_FRAME_WORDS - 1));

  always_comb
  begin
    ctrl_en_next       = ctrl_en_reg;
    sp_next            = sp_reg;
    lvlmask_next       = lvlmask_reg;
    overrun_next       = overrun_reg;
    last_code_next     = last_code_reg;
    last_nonrecov_next = last_nonrecov_reg;
    last_cantrst_next  = last_cantrst_reg;
    count_next         = count_reg;
    if (wr_en)
    begin
      case (wr_addr)
        MCF_OFF_CTRL:   ctrl_en_next = wr_data[MCF_CTRL_EN_BIT];
        MCF_OFF_SP:     sp_next = wr_data;
        MCF_OFF_LVLMSK: lvlmask_next = wr_data;
        MCF_OFF_STATUS:
        begin
          if (wr_data[MCF_ST_OVERRUN_BIT])
            overrun_next = 1'b0;
        end
        default:        ctrl_en_next = ctrl_en_reg;
      endcase
    end
    // A check that arrives while a frame is still going out cannot be framed
    if (enc_hit && ctrl_en_reg && (state_reg != MCF_ST_IDLE))
      overrun_next = 1'b1;
    if (start)
    begin
      last_code_next     = enc_code;
      last_nonrecov_next = enc_nonrecov;
      last_cantrst_next  = cannot_restart_flag;
    end
    // Stack pointer moves down past the whole frame; wins over a bus write
    if (accept && last_word)
    begin
      sp_next    = base_reg - MCF_FRAME_BYTES;
      count_next = count_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_en_reg       <= MCF_RST_CTRL[MCF_CTRL_EN_BIT];
      sp_reg            <= MCF_RST_SP;
      lvlmask_reg       <= MCF_RST_LVLMSK;
      overrun_reg       <= 1'b0;
      last_code_reg     <= 32'h0000_0000;
      last_nonrecov_reg <= 1'b0;
      last_cantrst_reg  <= 1'b0;
      count_reg         <= 32'h0000_0000;
    end
    else
    begin
      ctrl_en_reg       <= ctrl_en_next;
      sp_reg            <= sp_next;
      lvlmask_reg       <= lvlmask_next;
      overrun_reg       <= overrun_next;
      last_code_reg     <= last_code_next;
      last_nonrecov_reg <= last_nonrecov_next;
      last_cantrst_reg  <= last_cantrst_next;
      count_reg         <= count_next;
    end
  end

  // Frame is snapshotted in one cycle so every word belongs to one instruction
  always_comb
  begin
    state_next     = state_reg;
    idx_next       = idx_reg;
    base_next      = base_reg;
    frame_next     = frame_reg;
    stk_valid_next = stk_valid_reg;
    stk_addr_next  = stk_addr_reg;
    stk_wdata_next = stk_wdata_reg;
    taken_next     = 1'b0;
    busy_next      = busy_reg;
    case (state_reg)
      MCF_ST_IDLE:
      begin
        if (start)
        begin
          // Pushed first sits deepest; count ends on top
          frame_next[0] = cur_psl;
          frame_next[1] = cur_pc;
          frame_next[2] = {cur_state2[31:16], cannot_restart_flag,
                           cur_state2[14:0]};
          frame_next[3] = cur_state1;
          frame_next[4] = cur_va;
          frame_next[5] = enc_code;
          frame_next[6] = MCF_BYTE_COUNT;
          base_next      = sp_reg;
          idx_next       = 3'h0;
          stk_valid_next = 1'b1;
          stk_addr_next  = sp_reg - 32'h0000_0004;
          stk_wdata_next = cur_psl;
          busy_next      = 1'b1;
          state_next     = MCF_ST_PUSH;
        end
      end
      MCF_ST_PUSH:
      begin
        if (accept)
        begin
          if (last_word)
          begin
            stk_valid_next = 1'b0;
            taken_next     = 1'b1;
            busy_next      = 1'b0;
            state_next     = MCF_ST_IDLE;
          end
          else
          begin
            idx_next       = idx_reg + 3'h1;
            stk_addr_next  = stk_addr_reg - 32'h0000_0004;
            stk_wdata_next = frame_reg[idx_reg + 3'h1];
          end
        end
      end
      default:
      begin
        stk_valid_next = 1'b0;
        busy_next      = 1'b0;
        state_next     = MCF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg     <= MCF_ST_IDLE;
      idx_reg       <= 3'h0;
      base_reg      <= 32'h0000_0000;
      for (int i = 0; i < MCF_FRAME_WORDS; i++)
        frame_reg[i] <= 32'h0000_0000;
      stk_valid_reg <= 1'b0;
      stk_addr_reg  <= 32'h0000_0000;
      stk_wdata_reg <= 32'h0000_0000;
      taken_reg     <= 1'b0;
      busy_reg      <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      idx_reg       <= idx_next;
      base_reg      <= base_next;
      frame_reg     <= frame_next;
      stk_valid_reg <= stk_valid_next;
      stk_addr_reg  <= stk_addr_next;
      stk_wdata_reg <= stk_wdata_next;
      taken_reg     <= taken_next;
      busy_reg      <= busy_next;
    end
  end

  assign stk_valid = stk_valid_reg;
  assign stk_addr  = stk_addr_reg;
  assign stk_wdata = stk_wdata_reg;
  assign mc_busy   = busy_reg;
  assign mc_taken  = taken_reg;

endmodule // mcf_frame_logic
`default_nettype wire

// *** sim/mcf_monitor.sv ***
// Port checker for the machine check frame logic.
// Assumes one clock domain, hclk, and hresetn asynchronous active low.
`timescale 1ns/1ps
`default_nettype none
module mcf_monitor
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] cur_psl,
  input wire logic        cannot_restart_flag,
  input wire logic        stk_valid,
  input wire logic [31:0] stk_addr,
  input wire logic [31:0] stk_wdata,
  input wire logic        stk_ready,
  input wire logic        mc_busy,
  input wire logic        mc_taken
);
  logic [2:0] idx_reg;
  logic [2:0] idx_next;
  logic       cr_reg;
  logic       cr_next;
  logic       acc;
  assign acc = stk_valid && stk_ready;
  // The flag copy follows the input while idle, so it freezes at the take edge
  always_comb
  begin
    idx_next = idx_reg;
    if (acc)
      idx_next = (idx_reg == 3'h6) ? 3'h0 : idx_reg + 3'h1;
    cr_next = mc_busy ? cr_reg : cannot_restart_flag;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx_reg <= 3'h0;
      cr_reg  <= 1'b0;
    end
    else
    begin
      idx_reg <= idx_next;
      cr_reg  <= cr_next;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_last_word;
    acc && idx_reg == 3'h6;
  endsequence
  sequence s_frame_done;
    mc_taken && !stk_valid && !mc_busy;
  endsequence
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not zero-wait OKAY");
  a_word_held: assert property (
    stk_valid && !stk_ready |=> stk_valid && $stable(stk_addr) && $stable(stk_wdata))
    else $error("frame word changed before acceptance");
  a_first_psl: assert property (
    $rose(stk_valid) |-> mc_busy && stk_wdata == $past(cur_psl))
    else $error("first frame word is not the status longword");
  a_addr_step: assert property (
    acc && idx_reg != 3'h6 |=> stk_valid && stk_addr == $past(stk_addr) - 32'h4)
    else $error("frame word address did not step down by four");
  a_restart_bit: assert property (
    stk_valid && idx_reg == 3'h2 |-> stk_wdata[15] == cr_reg)
    else $error("state word bit 15 differs from restart flag");
  a_count_top: assert property (s_last_word |-> stk_wdata == 32'h0000_0010)
    else $error("last frame word is not the byte count");
  a_frame_done: assert property (s_last_word |=> s_frame_done ##1 !mc_taken)
    else $error("frame end not flagged for exactly one cycle");
  a_taken_idle: assert property (mc_taken |-> !$past(mc_taken) && !mc_busy)
    else $error("completion pulse too long or while busy");
endmodule // mcf_monitor
`default_nettype wire

// *** sim/mcf_stack_sink.sv ***
// Stack side stand-in and handler decision for the frame logic.
// Assumes frame words are offered on hclk and held until accepted.
`timescale 1ns/1ps
`default_nettype none
module mcf_stack_sink
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        slow,
  input  wire logic        stk_valid,
  input  wire logic [31:0] stk_addr,
  input  wire logic [31:0] stk_wdata,
  output logic             stk_ready
);
  logic [31:0] mem [logic [31:0]];
  // Only reads restart; every other class ends the process or system
  function automatic logic recoverable(input logic [31:0] code, input logic fpd,
                                       input logic cr);
    return (code == 32'h80 || code == 32'h81) && (fpd || !cr);
  endfunction
  // Slow mode stalls every other cycle so words must wait
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stk_ready <= 1'b0;
    else
    begin
      if (stk_valid && stk_ready)
        mem[stk_addr] = stk_wdata;
      stk_ready <= slow ? ~stk_ready : 1'b1;
    end
  end
endmodule // mcf_stack_sink
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the machine check frame logic.
// Assumes the sink model and the port checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mcf_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic        mem_err_valid = 1'b0, mem_err_write = 1'b0, pte_check_valid = 1'b0;
  logic        pte_check_modify = 1'b0, irq_req_valid = 1'b0, str_check_valid = 1'b0;
  logic        cannot_restart_flag = 1'b0, hready, hreadyout, hresp;
  logic        stk_valid, stk_ready, mc_busy, mc_taken;
  logic [1:0]  htrans = 2'h0, str_check_state = 2'h0;
  logic [4:0]  irq_req_level = 5'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pte_check_va = 32'h0, cur_pc = 32'h0;
  logic [31:0] cur_psl = 32'h0, cur_va = 32'h0, cur_state1 = 32'h0, cur_state2 = 32'h0;
  logic [31:0] hrdata, stk_addr, stk_wdata, sp, q, cnt;
  logic [31:0] ex [7];
  mcf_target_t mem_err_target = MCF_TGT_OPERAND;
  int          err_count = 0, comparisons = 0;
  // Kind, argument, expected code; code zero means no check may be taken
  localparam logic [15:0] CASES [24] = '{
    16'h0080, 16'h0180, 16'h0280, 16'h0381, 16'h0481, 16'h0581, 16'h0882, 16'h0982,
    16'h0B83, 16'h0C83, 16'h0E83, 16'h1005, 16'h1106, 16'h1407, 16'h1508, 16'h2309,
    16'h330A, 16'h1200, 16'h1600, 16'h2400, 16'h3000, 16'h3100, 16'h3200, 16'h0D83};
  assign hready = hreadyout;
  mcf_frame_logic mcf_frame_logic_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .mem_err_valid(mem_err_valid), .mem_err_write(mem_err_write),
    .mem_err_target(mem_err_target), .pte_check_valid(pte_check_valid),
    .pte_check_modify(pte_check_modify), .pte_check_va(pte_check_va),
    .irq_req_valid(irq_req_valid), .irq_req_level(irq_req_level),
    .str_check_valid(str_check_valid), .str_check_state(str_check_state),
    .cur_pc(cur_pc), .cur_psl(cur_psl), .cur_va(cur_va), .cur_state1(cur_state1),
    .cur_state2(cur_state2), .cannot_restart_flag(cannot_restart_flag),
    .stk_valid(stk_valid), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .stk_ready(stk_ready), .mc_busy(mc_busy), .mc_taken(mc_taken));
  mcf_stack_sink mcf_stack_sink_i (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .stk_valid(stk_valid), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .stk_ready(stk_ready));
  initial
  begin
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // One-cycle pulse on the condition picked by the case kind
  task automatic fire(input logic [15:0] c);
    mem_err_valid <= c[15:12] == 4'h0;
    mem_err_write <= c[11];
    mem_err_target <= mcf_target_t'(c[10:8]);
    pte_check_valid <= c[15:12] == 4'h1;
    pte_check_modify <= c[10];
    pte_check_va <= {c[9:8], 30'h0000_1230};
    irq_req_valid <= c[15:12] == 4'h2;
    irq_req_level <= {1'b0, c[11:8]};
    str_check_valid <= c[15:12] == 4'h3;
    str_check_state <= c[9:8];
    @(posedge hclk);
    mem_err_valid <= 1'b0;
    pte_check_valid <= 1'b0;
    irq_req_valid <= 1'b0;
    str_check_valid <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #300_000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(MCF_OFF_CTRL, MCF_RST_CTRL);
    rd(MCF_OFF_SP, MCF_RST_SP);
    rd(MCF_OFF_LVLMSK, MCF_RST_LVLMSK);
    rd(MCF_OFF_STATUS, 32'h0);
    rd(MCF_OFF_COUNT, 32'h0);
    rd(8'h18, 32'h0);
    ahb(1'b1, MCF_OFF_CODE, 32'h55);
    rd(MCF_OFF_CODE, 32'h0);
    ahb(1'b1, MCF_OFF_SP, 32'h0000_1000);
    ahb(1'b1, MCF_OFF_LVLMSK, 32'hFFFF_FFF7);
    sp = 32'h0000_1000;
    cnt = 32'h0;
    rd(MCF_OFF_SP, sp);
    for (int i = 0; i < 24; i++)
    begin
      ex[0] = 32'h0410_0000 + 32'(i);
      ex[1] = 32'h2000_0100 + 32'(i);
      ex[2] = {16'h1234, i[0], 15'h5678};
      ex[3] = 32'hE500_0000 + 32'(i);
      ex[4] = 32'h0000_3000 + 32'(i);
      ex[5] = {24'h0, CASES[i][7:0]};
      ex[6] = 32'h0000_0010;
      cur_psl <= ex[0];
      cur_pc <= ex[1];
      cur_state2 <= {16'h1234, i[1], 15'h5678};
      cur_state1 <= ex[3];
      cur_va <= ex[4];
      cannot_restart_flag <= i[0];
      slow <= i[1];
      fire(CASES[i]);
      if (ex[5] == 32'h0)
      begin
        repeat (3) @(posedge hclk);
        chk({31'h0, mc_busy}, 32'h0);
      end
      else
      begin
        while (mc_taken !== 1'b1)
          @(posedge hclk);
        for (int k = 0; k < 7; k++)
          chk(mcf_stack_sink_i.mem[sp - 32'(4 * k + 4)], ex[k]);
        sp = sp - 32'h1C;
        cnt = cnt + 32'h1;
        rd(MCF_OFF_CODE, ex[5]);
        rd(MCF_OFF_STATUS, {28'h0, i[0],
           ~mcf_stack_sink_i.recoverable(ex[5], 1'b1, i[0]), 2'h0});
        rd(MCF_OFF_SP, sp);
        rd(MCF_OFF_COUNT, cnt);
      end
    end
    // A second check while the frame goes out is dropped and flags overrun
    fire(16'h0080);
    @(posedge hclk);
    fire(16'h0180);
    while (mc_taken !== 1'b1)
      @(posedge hclk);
    cnt = cnt + 32'h1;
    rd(MCF_OFF_STATUS, {28'h0, cannot_restart_flag, 3'h2});
    ahb(1'b1, MCF_OFF_STATUS, 32'h2);
    rd(MCF_OFF_STATUS, {28'h0, cannot_restart_flag, 3'h0});
    ahb(1'b1, MCF_OFF_CTRL, 32'h0);
    fire(16'h0080);
    repeat (3) @(posedge hclk);
    chk({31'h0, mc_busy}, 32'h0);
    rd(MCF_OFF_COUNT, cnt);
    wrap_up();
  end
endmodule // testbench
bind mcf_frame_logic mcf_monitor mcf_monitor_i (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .cur_psl(cur_psl),
  .cannot_restart_flag(cannot_restart_flag), .stk_valid(stk_valid),
  .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_ready(stk_ready),
  .mc_busy(mc_busy), .mc_taken(mc_taken));
`default_nettype wire
